// *** logic/hsw_pkg.sv ***
// hsw_pkg: command codes, field layout, reset values and command kinds
// shared by the hot-swap status and warning register bank.
// assumes a bus engine outside decodes frames into single commands.
package hsw_pkg;
    localparam int ADC_W = 12;
    localparam int WORD_W = 16;
    localparam int CODE_W = 8;

    localparam logic [7:0] CODE_OPERATION = 8'h01;
    localparam logic [7:0] CODE_CLEAR_LATCHED = 8'h03;
    localparam logic [7:0] CODE_VIN_OV_WARN = 8'h57;
    localparam logic [7:0] CODE_VIN_UV_WARN = 8'h58;
    localparam logic [7:0] CODE_SUMMARY_STATUS = 8'h78;
    localparam logic [7:0] CODE_SECONDARY_CURRENT = 8'hD7;

    localparam logic [11:0] RST_VIN_OV_WARN = 12'hFFF;
    localparam logic [11:0] RST_VIN_UV_WARN = 12'h000;
    localparam logic [11:0] RST_SECONDARY_CURRENT = 12'h000;
    localparam logic [7:0] RST_SUMMARY_STATUS = 8'h00;
    localparam logic [7:0] RST_OPERATION = 8'h80;

    localparam int OP_ON_BIT = 7;
    localparam int ST_GATE_OFF = 6;
    localparam int ST_OC_FAULT = 4;
    localparam int ST_UV_FAULT = 3;
    localparam int ST_COMM_ERR = 1;
    localparam int ST_OTHER = 0;

    typedef enum logic [1:0] {
        HSW_CMD_SEND,
        HSW_CMD_WRITE,
        HSW_CMD_READ
    } hsw_cmd_kind_t;
endpackage

// *** logic/hsw_sync3.sv ***
// hsw_sync3: three-stage synchroniser per bit for pin inputs.
// assumes inputs are asynchronous to clock; output moves only
// once stages two and three agree.
`timescale 1ns/1ps
module hsw_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // stage1 feeds stage2 only, never any logic
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    stage1[i] <= RESET_VALUE[i];
                    stage2[i] <= RESET_VALUE[i];
                    stage3[i] <= RESET_VALUE[i];
                    sync_out[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        sync_out[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // hsw_sync3

// *** logic/hsw_limit_cmp.sv ***
// hsw_limit_cmp: compares one adc code against a threshold.
// assumes both operands on the same clock; purely combinational.
`timescale 1ns/1ps
module hsw_limit_cmp #(
    parameter int WIDTH = 12
) (
    input wire logic [WIDTH-1:0] value,
    input wire logic [WIDTH-1:0] limit,
    input wire logic over_limit,
    output logic hit
);
    // over_limit high: strictly above; low: strictly below
    always_comb begin
        if (over_limit) begin
            hit = value > limit;
        end else begin
            hit = value < limit;
        end
    end
endmodule // hsw_limit_cmp

// *** logic/hsw_status_regs.sv ***
// Behaviour
// - read/write word 0xD7: secondary current threshold [11:0], reset 0x0000
// - direction-select bit picks undercurrent or overcurrent comparison
// - read/write word 0x57: input overvoltage warning threshold, reset 0x0FFF
// - read/write word 0x58: input undervoltage warn threshold, reset 0x0000
// - threshold words read zero in bits 15 to 12
// - read of 0x78 returns summary status, reset 0x00, bits 7,5,2 zero
// - bit 6 live: one while gate drive is disabled
// - gate-off covers overcurrent latch-off, low supply pin, host off
// - bit 4 latches when overcurrent timer expires and gate shuts down
// - bit 3 latches on undervoltage fault at low supply pin
// - bit 1 latches on unsupported code, bad check byte, bad message
// - bit 0 live: another status command holds an active bit
// - clearing operation enable bit disables output, sets gate-off
//
// hsw_status_regs: command-level register bank of the hot-swap monitor.
// assumes a bus engine delivers one decoded command per cmd_valid pulse.
`timescale 1ns/1ps
module hsw_status_regs
    import hsw_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire hsw_pkg::hsw_cmd_kind_t cmd_kind,
    input wire logic [hsw_pkg::CODE_W-1:0] cmd_code,
    input wire logic [hsw_pkg::WORD_W-1:0] cmd_wdata,
    input wire logic cmd_pec_error,
    input wire logic cmd_frame_error,
    output logic rsp_valid,
    output logic [hsw_pkg::WORD_W-1:0] rsp_data,
    input wire logic low_supply_detect_pin,
    input wire logic overcurrent_timer_expired_pin,
    input wire logic secondary_current_direction_select,
    input wire logic other_status_active,
    input wire logic adc_valid,
    input wire logic [hsw_pkg::ADC_W-1:0] adc_current,
    input wire logic [hsw_pkg::ADC_W-1:0] adc_vin,
    output logic gate_enable,
    output logic [7:0] summary_status,
    output logic secondary_current_warn,
    output logic input_overvoltage_warn,
    output logic input_undervoltage_warn,
    output logic other_status_pending_flag
);
    import hsw_pkg::*;

    logic [ADC_W-1:0] secondary_current_threshold;
    logic [ADC_W-1:0] input_overvoltage_warn_threshold;
    logic [ADC_W-1:0] input_undervoltage_warn_threshold;
    logic output_enable;
    logic overcurrent_shutdown_flag;
    logic undervoltage_pin_fault_flag;
    logic bus_communication_error_flag;
    logic gate_latched_off;
    logic supply_low;
    logic oc_expired;
    logic oc_expired_d;
    logic oc_trip;
    logic hit_current;
    logic hit_ov;
    logic hit_uv;
    logic wr_word;
    logic is_clear;
    logic bad_cmd;
    logic next_gate_enable;
    logic [7:0] next_status;

    // pins come from the analog side, so they are synchronised
    hsw_sync3 #(
        .WIDTH(2),
        .RESET_VALUE(2'h0)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({overcurrent_timer_expired_pin, low_supply_detect_pin}),
        .sync_out({oc_expired, supply_low})
    );

    // only the current limit has a selectable direction
    hsw_limit_cmp #(.WIDTH(ADC_W)) u_cmp_current (
        .value(adc_current),
        .limit(secondary_current_threshold),
        .over_limit(secondary_current_direction_select),
        .hit(hit_current)
    );

    hsw_limit_cmp #(.WIDTH(ADC_W)) u_cmp_ov (
        .value(adc_vin),
        .limit(input_overvoltage_warn_threshold),
        .over_limit(1'b1),
        .hit(hit_ov)
    );

    hsw_limit_cmp #(.WIDTH(ADC_W)) u_cmp_uv (
        .value(adc_vin),
        .limit(input_undervoltage_warn_threshold),
        .over_limit(1'b0),
        .hit(hit_uv)
    );

    // command decode; a kind that does not suit the code is an error
    always_comb begin
        wr_word = 1'b0;
        is_clear = 1'b0;
        bad_cmd = 1'b0;
        if (cmd_valid) begin
            // a damaged frame is refused whatever its code says
            if (cmd_pec_error || cmd_frame_error) begin
                bad_cmd = 1'b1;
            end else begin
                unique case (cmd_code)
                    CODE_SECONDARY_CURRENT, CODE_VIN_OV_WARN,
                    CODE_VIN_UV_WARN, CODE_OPERATION: begin
                        wr_word = cmd_kind == HSW_CMD_WRITE;
                        bad_cmd = cmd_kind == HSW_CMD_SEND;
                    end
                    CODE_SUMMARY_STATUS: begin
                        bad_cmd = cmd_kind != HSW_CMD_READ;
                    end
                    CODE_CLEAR_LATCHED: begin
                        is_clear = cmd_kind == HSW_CMD_SEND;
                        bad_cmd = cmd_kind != HSW_CMD_SEND;
                    end
                    default: begin
                        bad_cmd = 1'b1;
                    end
                endcase
            end
        end
    end

    // upper four written bits are dropped, so reads return zero there
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            secondary_current_threshold <= RST_SECONDARY_CURRENT;
            input_overvoltage_warn_threshold <= RST_VIN_OV_WARN;
            input_undervoltage_warn_threshold <= RST_VIN_UV_WARN;
            output_enable <= RST_OPERATION[OP_ON_BIT];
        end else if (wr_word) begin
            unique case (cmd_code)
                CODE_SECONDARY_CURRENT: begin
                    secondary_current_threshold <= cmd_wdata[ADC_W-1:0];
                end
                CODE_VIN_OV_WARN: begin
                    input_overvoltage_warn_threshold <=
                        cmd_wdata[ADC_W-1:0];
                end
                CODE_VIN_UV_WARN: begin
                    input_undervoltage_warn_threshold <=
                        cmd_wdata[ADC_W-1:0];
                end
                // operation register keeps its enable bit only
                default: begin
                    output_enable <= cmd_wdata[OP_ON_BIT];
                end
            endcase
        end
    end

    // read answer one cycle after the command
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            // refused reads still answer, with zero data, so no host hangs
            rsp_valid <= cmd_valid && cmd_kind == HSW_CMD_READ;
            rsp_data <= 16'h0000;
            if (cmd_valid && cmd_kind == HSW_CMD_READ && !bad_cmd) begin
                unique case (cmd_code)
                    CODE_SECONDARY_CURRENT: begin
                        rsp_data <= {4'h0, secondary_current_threshold};
                    end
                    CODE_VIN_OV_WARN: begin
                        rsp_data <=
                            {4'h0, input_overvoltage_warn_threshold};
                    end
                    CODE_VIN_UV_WARN: begin
                        rsp_data <=
                            {4'h0, input_undervoltage_warn_threshold};
                    end
                    CODE_OPERATION: begin
                        rsp_data <= {8'h00, output_enable, 7'h00};
                    end
                    default: begin
                        rsp_data <= {8'h00, summary_status};
                    end
                endcase
            end
        end
    end

    // the pin edge counts only while the gate is still on
    always_comb begin
        oc_trip = oc_expired && !oc_expired_d && gate_enable;
    end

    // overcurrent latch-off holds the gate down until the host cycles
    // the enable bit; clearing flags alone does not restart the load
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gate_latched_off <= 1'b0;
            oc_expired_d <= 1'b0;
        end else begin
            oc_expired_d <= oc_expired;
            if (oc_trip) begin
                gate_latched_off <= 1'b1;
            end else if (!output_enable) begin
                gate_latched_off <= 1'b0;
            end
        end
    end

    // any one cause is enough to pull the gate down
    always_comb begin
        next_gate_enable = output_enable && !supply_low
            && !gate_latched_off;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gate_enable <= 1'b0;
        end else begin
            gate_enable <= next_gate_enable;
        end
    end

    // set wins over clear so an event in the clear cycle survives
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overcurrent_shutdown_flag <= 1'b0;
            undervoltage_pin_fault_flag <= 1'b0;
            bus_communication_error_flag <= 1'b0;
        end else begin
            if (oc_trip) begin
                overcurrent_shutdown_flag <= 1'b1;
            end else if (is_clear) begin
                overcurrent_shutdown_flag <= 1'b0;
            end
            if (supply_low) begin
                undervoltage_pin_fault_flag <= 1'b1;
            end else if (is_clear) begin
                undervoltage_pin_fault_flag <= 1'b0;
            end
            if (bad_cmd) begin
                bus_communication_error_flag <= 1'b1;
            end else if (is_clear) begin
                bus_communication_error_flag <= 1'b0;
            end
        end
    end

    // warnings latch on a compare hit; writes of limits leave them alone
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            secondary_current_warn <= 1'b0;
            input_overvoltage_warn <= 1'b0;
            input_undervoltage_warn <= 1'b0;
        end else begin
            if (adc_valid && hit_current) begin
                secondary_current_warn <= 1'b1;
            end else if (is_clear) begin
                secondary_current_warn <= 1'b0;
            end
            if (adc_valid && hit_ov) begin
                input_overvoltage_warn <= 1'b1;
            end else if (is_clear) begin
                input_overvoltage_warn <= 1'b0;
            end
            if (adc_valid && hit_uv) begin
                input_undervoltage_warn <= 1'b1;
            end else if (is_clear) begin
                input_undervoltage_warn <= 1'b0;
            end
        end
    end

    always_comb begin
        // bit 6 trails the gate by one cycle; readers must allow the lag
        next_status = RST_SUMMARY_STATUS;
        next_status[ST_GATE_OFF] = !gate_enable;
        next_status[ST_OC_FAULT] = overcurrent_shutdown_flag;
        next_status[ST_UV_FAULT] = undervoltage_pin_fault_flag;
        next_status[ST_COMM_ERR] = bus_communication_error_flag;
        next_status[ST_OTHER] = other_status_active
            || secondary_current_warn || input_overvoltage_warn
            || input_undervoltage_warn;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            summary_status <= RST_SUMMARY_STATUS;
            other_status_pending_flag <= 1'b0;
        end else begin
            summary_status <= next_status;
            // copy of bit 0 so outside logic need not decode the byte
            other_status_pending_flag <= next_status[ST_OTHER];
        end
    end
endmodule // hsw_status_regs

// *** tb/hsw_status_regs_sva.sv ***
// hsw_status_regs_sva: port-level checks of the status register bank.
// assumes it is bound into every hsw_status_regs instance.
`timescale 1ns/1ps
module hsw_status_regs_sva
    import hsw_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire hsw_pkg::hsw_cmd_kind_t cmd_kind,
    input wire logic [hsw_pkg::CODE_W-1:0] cmd_code,
    input wire logic [hsw_pkg::WORD_W-1:0] cmd_wdata,
    input wire logic cmd_pec_error,
    input wire logic cmd_frame_error,
    input wire logic rsp_valid,
    input wire logic [hsw_pkg::WORD_W-1:0] rsp_data,
    input wire logic gate_enable,
    input wire logic [7:0] summary_status,
    input wire logic other_status_pending_flag
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic good;
    logic rd_thr;
    logic clr_cmd;
    assign good = cmd_valid && !cmd_pec_error && !cmd_frame_error;
    assign rd_thr = good && cmd_kind == HSW_CMD_READ && cmd_code inside
        {CODE_VIN_OV_WARN, CODE_VIN_UV_WARN, CODE_SECONDARY_CURRENT};
    assign clr_cmd = good && cmd_kind == HSW_CMD_SEND
        && cmd_code == CODE_CLEAR_LATCHED;
    rsv_zero_a: assert property (
        {summary_status[7], summary_status[5], summary_status[2]} == 3'h0)
        else $error("reserved status bit set");
    read_answer_a: assert property (
        cmd_valid && cmd_kind == HSW_CMD_READ |=> rsp_valid)
        else $error("read left unanswered");
    thr_zero_a: assert property (rd_thr |=> rsp_data[15:12] == 4'h0)
        else $error("threshold upper bits not zero");
    // one-cycle lag of the gate bit; skipped just after reset
    gate_live_a: assert property (
        $past(rst_n, 2) |-> summary_status[6] == !$past(gate_enable))
        else $error("gate-off bit does not follow gate");
    oc_off_a: assert property (
        $rose(summary_status[4]) |-> ##[0:2] !gate_enable)
        else $error("overcurrent flag without gate shutdown");
    err_set_a: assert property (
        cmd_valid && (cmd_pec_error || cmd_frame_error)
        |-> ##2 summary_status[1])
        else $error("bad frame did not set error bit");
    err_hold_a: assert property (
        $fell(summary_status[1]) |-> $past(clr_cmd, 2))
        else $error("error bit dropped without clear");
    other_eq_a: assert property (
        other_status_pending_flag == summary_status[0])
        else $error("pending flag differs from bit 0");
    gate_cmd_a: assert property (
        good && cmd_kind == HSW_CMD_WRITE && cmd_code == CODE_OPERATION
        && !cmd_wdata[OP_ON_BIT] |-> ##[1:3] summary_status[6])
        else $error("output off did not raise gate-off");
endmodule // hsw_status_regs_sva

bind hsw_status_regs hsw_status_regs_sva u_sva (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_pec_error(cmd_pec_error), .cmd_frame_error(cmd_frame_error),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .gate_enable(gate_enable),
    .summary_status(summary_status),
    .other_status_pending_flag(other_status_pending_flag)
);

// *** tb/hsw_host_model.sv ***
// hsw_host_model: bus host issuing one decoded command at a time.
// assumes commands are taken on the rising edge of clock.
`timescale 1ns/1ps
module hsw_host_model
    import hsw_pkg::*;
(
    input wire logic clock,
    output logic cmd_valid,
    output hsw_pkg::hsw_cmd_kind_t cmd_kind,
    output logic [hsw_pkg::CODE_W-1:0] cmd_code,
    output logic [hsw_pkg::WORD_W-1:0] cmd_wdata,
    output logic cmd_pec_error,
    output logic cmd_frame_error,
    input wire logic rsp_valid,
    input wire logic [hsw_pkg::WORD_W-1:0] rsp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_kind = HSW_CMD_SEND;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        {cmd_pec_error, cmd_frame_error} = 2'h0;
    end
    task automatic xfer(input hsw_cmd_kind_t k, input logic [7:0] c,
        input logic [15:0] d, input logic [1:0] err, output logic [15:0] q);
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_code = c;
        cmd_wdata = d;
        {cmd_pec_error, cmd_frame_error} = err;
        @(posedge clock);
        #1;
        // marker so a missing answer never passes for data
        q = (rsp_valid === 1'b1) ? rsp_data : 16'hBAD0;
        cmd_valid = 1'b0;
        {cmd_pec_error, cmd_frame_error} = 2'h0;
        // released lines scramble, stale values must not look held
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
endmodule // hsw_host_model

// *** tb/testbench.sv ***
// testbench: drives the status register bank through the host model.
// assumes a 20 MHz clock and a reset held for 20 cycles.
`timescale 1ns/1ps
module testbench;
    import hsw_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, low_supply_detect_pin = 1'b0;
    logic overcurrent_timer_expired_pin = 1'b0, adc_valid = 1'b0;
    logic secondary_current_direction_select = 1'b0;
    logic other_status_active = 1'b0;
    logic [11:0] adc_current = 12'h000, adc_vin = 12'h000;
    logic cmd_valid, cmd_pec_error, cmd_frame_error, rsp_valid;
    hsw_cmd_kind_t cmd_kind;
    logic [7:0] cmd_code, summary_status;
    logic [15:0] cmd_wdata, rsp_data, q, warns;
    logic gate_enable, secondary_current_warn, input_overvoltage_warn;
    logic input_undervoltage_warn, other_status_pending_flag;
    int error_cnt = 0, checks = 0, cyc_cnt = 0;
    logic [7:0] tc[3] = '{CODE_VIN_OV_WARN, CODE_VIN_UV_WARN,
        CODE_SECONDARY_CURRENT};
    hsw_cmd_kind_t rk[6] = '{HSW_CMD_READ, HSW_CMD_WRITE, HSW_CMD_SEND,
        HSW_CMD_WRITE, HSW_CMD_WRITE, HSW_CMD_READ};
    logic [7:0] rc[6] = '{8'hEE, 8'h78, 8'h57, 8'h57, 8'h58, 8'h03};
    logic [1:0] re[6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
    assign warns = {13'h0, secondary_current_warn, input_overvoltage_warn,
        input_undervoltage_warn};
    always #25 clock = ~clock;
    hsw_host_model host (.clock(clock), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_pec_error(cmd_pec_error), .cmd_frame_error(cmd_frame_error),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    hsw_status_regs dut (.clock(clock), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_pec_error(cmd_pec_error),
        .cmd_frame_error(cmd_frame_error), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .low_supply_detect_pin(low_supply_detect_pin),
        .overcurrent_timer_expired_pin(overcurrent_timer_expired_pin),
        .secondary_current_direction_select(
            secondary_current_direction_select),
        .other_status_active(other_status_active), .adc_valid(adc_valid),
        .adc_current(adc_current), .adc_vin(adc_vin),
        .gate_enable(gate_enable), .summary_status(summary_status),
        .secondary_current_warn(secondary_current_warn),
        .input_overvoltage_warn(input_overvoltage_warn),
        .input_undervoltage_warn(input_undervoltage_warn),
        .other_status_pending_flag(other_status_pending_flag));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.xfer(HSW_CMD_WRITE, c, d, 2'h0, q);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        host.xfer(HSW_CMD_READ, c, 16'h0000, 2'h0, q);
        chk(q, exp);
    endtask
    task automatic clr();
        host.xfer(HSW_CMD_SEND, CODE_CLEAR_LATCHED, 16'h0000, 2'h0, q);
        cyc(2);
    endtask
    task automatic adc(input logic [11:0] cur, input logic [11:0] vin);
        @(posedge clock);
        #1;
        adc_valid = 1'b1;
        adc_current = cur;
        adc_vin = vin;
        cyc(1);
        adc_valid = 1'b0;
        cyc(2);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc_cnt++;
        // sequence needs well under 1000 cycles
        if (cyc_cnt == 4000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        cyc(20);
        rst_n = 1'b1;
        rd(CODE_SECONDARY_CURRENT, 16'h0000);
        rd(CODE_VIN_OV_WARN, 16'h0FFF);
        rd(CODE_VIN_UV_WARN, 16'h0000);
        rd(CODE_SUMMARY_STATUS, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(tc[i], 16'hF123);
            rd(tc[i], 16'h0123);
        end
        wr(CODE_VIN_OV_WARN, 16'h0800);
        wr(CODE_VIN_UV_WARN, 16'h0100);
        wr(CODE_SECONDARY_CURRENT, 16'h0400);
        // equal codes sit on the boundary: strict compares stay quiet
        adc(12'h400, 12'h800);
        chk(warns, 16'h0000);
        secondary_current_direction_select = 1'b1;
        adc(12'h401, 12'h400);
        chk(warns, 16'h0004);
        clr();
        chk(warns, 16'h0000);
        secondary_current_direction_select = 1'b0;
        adc(12'h3FF, 12'h801);
        chk(warns, 16'h0006);
        wr(CODE_VIN_OV_WARN, 16'h0FFF);
        adc(12'h400, 12'h0FF);
        chk(warns, 16'h0007);
        rd(CODE_SUMMARY_STATUS, 16'h0001);
        clr();
        rd(CODE_SUMMARY_STATUS, 16'h0000);
        other_status_active = 1'b1;
        cyc(3);
        rd(CODE_SUMMARY_STATUS, 16'h0001);
        chk({15'h0, other_status_pending_flag}, 16'h0001);
        other_status_active = 1'b0;
        wr(CODE_OPERATION, 16'h0000);
        cyc(3);
        chk({15'h0, gate_enable}, 16'h0000);
        rd(CODE_OPERATION, 16'h0000);
        rd(CODE_SUMMARY_STATUS, 16'h0040);
        wr(CODE_OPERATION, 16'h0080);
        cyc(3);
        rd(CODE_SUMMARY_STATUS, 16'h0000);
        low_supply_detect_pin = 1'b1;
        cyc(10);
        rd(CODE_SUMMARY_STATUS, 16'h0048);
        low_supply_detect_pin = 1'b0;
        cyc(10);
        chk({15'h0, summary_status[3]}, 16'h0001);
        clr();
        chk({15'h0, summary_status[3]}, 16'h0000);
        wr(CODE_OPERATION, 16'h0000);
        wr(CODE_OPERATION, 16'h0080);
        cyc(3);
        overcurrent_timer_expired_pin = 1'b1;
        cyc(10);
        rd(CODE_SUMMARY_STATUS, 16'h0050);
        overcurrent_timer_expired_pin = 1'b0;
        cyc(6);
        rd(CODE_SUMMARY_STATUS, 16'h0050);
        clr();
        rd(CODE_SUMMARY_STATUS, 16'h0040);
        wr(CODE_OPERATION, 16'h0000);
        wr(CODE_OPERATION, 16'h0080);
        cyc(3);
        rd(CODE_SUMMARY_STATUS, 16'h0000);
        rd(CODE_OPERATION, 16'h0080);
        for (int i = 0; i < 6; i++) begin
            host.xfer(rk[i], rc[i], 16'h0AAA, re[i], q);
            if (rk[i] == HSW_CMD_READ) chk(q, 16'h0000);
            cyc(2);
            chk({15'h0, summary_status[1]}, 16'h0001);
            clr();
        end
        rd(CODE_VIN_OV_WARN, 16'h0FFF);
        rd(CODE_VIN_UV_WARN, 16'h0100);
        rd(CODE_SUMMARY_STATUS, 16'h0000);
        close_out();
    end
endmodule // testbench
